// ===== rtl/bdm_pkg.sv
// Constants, address map and decode functions of the banked data memory
//
// Contract
// - Data memory is volatile, eight bits wide
// - General purpose locations are readable and writable
// - Protected special locations ignore program writes
// - Two banks, chosen by software bank pointer
// - Special registers shared; eeprom_control only bank 1
// - Address space starts at 00H
// - Indirect ports have no storage, use pointers
// - Indirect port 0 reaches bank 0 only
// - Ports 1, 2: bank from high byte
// - Port addressed indirectly reads 00H, ignores writes
// - Five pointer bytes are real read/write storage
// - Full-space direct access reaches every bank
// - Accumulator holds ALU results
// - Register-to-register moves go through accumulator
package bdm_pkg;

   // ------------------------------------------------------------------
   // Widths and sizes
   // ------------------------------------------------------------------
   localparam int DW      = 8;
   localparam int AW      = 8;
   localparam int IW      = 9;
   localparam int DEPTH   = 384;

   // ------------------------------------------------------------------
   // Special function addresses
   // ------------------------------------------------------------------
   localparam logic [AW-1:0] ADDR_BASE = 8'h00;
   localparam logic [AW-1:0] ADDR_IND0 = 8'h00;
   localparam logic [AW-1:0] ADDR_PTR0 = 8'h01;
   localparam logic [AW-1:0] ADDR_IND1 = 8'h02;
   localparam logic [AW-1:0] ADDR_P1L  = 8'h03;
   localparam logic [AW-1:0] ADDR_P1H  = 8'h04;
   localparam logic [AW-1:0] ADDR_ACC  = 8'h05;
   localparam logic [AW-1:0] ADDR_PROT = 8'h08;
   localparam logic [AW-1:0] ADDR_IND2 = 8'h0C;
   localparam logic [AW-1:0] ADDR_P2L  = 8'h0D;
   localparam logic [AW-1:0] ADDR_P2H  = 8'h0E;
   localparam logic [AW-1:0] ADDR_BSEL = 8'h0F;
   localparam logic [AW-1:0] ADDR_EEC  = 8'h40;

   // ------------------------------------------------------------------
   // Fields, storage regions and reset values
   // ------------------------------------------------------------------
   localparam int            GP_BIT    = 7;
   localparam int            BANK_BIT  = 0;
   localparam logic [1:0]    REG_SFR   = 2'h0;
   localparam logic [1:0]    REG_GP0   = 2'h1;
   localparam logic [1:0]    REG_GP1   = 2'h2;
   localparam logic [DW-1:0] PTR_RST   = 8'h00;
   localparam logic [DW-1:0] ZERO_DATA = 8'h00;

   // True for the three indirect port addresses
   function automatic logic is_port(input logic [AW-1:0] a);
      return (a == ADDR_IND0) || (a == ADDR_IND1) || (a == ADDR_IND2);
   endfunction

   // Physical row: shared special area, then one general area per bank
   function automatic logic [IW-1:0] ram_index(input logic [AW-1:0] a,
                                               input logic            b);
      logic [1:0] region;
      region = a[GP_BIT] ? (b ? REG_GP1 : REG_GP0) : REG_SFR;
      return {region, a[GP_BIT-1:0]};
   endfunction

endpackage

// ===== rtl/bdm_acc_if.sv
// Carrier between the top and the address router
interface bdm_acc_if;
   import bdm_pkg::*;

   logic [AW-1:0] addr;
   logic          full;
   logic          full_bank;
   logic          bank_sel;
   logic [DW-1:0] p0;
   logic [DW-1:0] p1l;
   logic [DW-1:0] p1h;
   logic [DW-1:0] p2l;
   logic [DW-1:0] p2h;
   logic [AW-1:0] tgt;
   logic          tbank;
   logic          null_hit;

   modport core  (output addr, full, full_bank, bank_sel, p0, p1l, p1h, p2l, p2h,
                  input tgt, tbank, null_hit);
   modport route (input addr, full, full_bank, bank_sel, p0, p1l, p1h, p2l, p2h,
                  output tgt, tbank, null_hit);
endinterface

// ===== rtl/bdm_ram.sv
// Storage array for shared special and banked general locations
module bdm_ram
   import bdm_pkg::*;
(
   // Clock
   input  wire logic          clk,
   // Write and address
   input  wire logic          we,
   input  wire logic [IW-1:0] idx,
   input  wire logic [DW-1:0] wdata,
   // Registered read data
   output logic      [DW-1:0] q
);

   // Volatile, no reset: contents are undefined after power up
   logic [DW-1:0] mem [DEPTH];

   // Read first: a write in the same cycle returns the old value, read data from a register
   always_ff @(posedge clk) begin
      if (we) begin
         mem[idx] <= wdata;
      end
      q <= mem[idx];
   end

endmodule

// ===== rtl/bdm_route.sv
// Resolves a core address into a physical location and bank
module bdm_route
   import bdm_pkg::*;
(
   // Request side and result side
   bdm_acc_if.route bus
);

   // ------------------------------------------------------------------
   // Port decode
   // ------------------------------------------------------------------
   logic hit0;
   logic hit1;
   logic hit2;
   logic direct_bank;

   assign hit0 = (bus.addr == ADDR_IND0);
   assign hit1 = (bus.addr == ADDR_IND1);
   assign hit2 = (bus.addr == ADDR_IND2);

   // Full-space form carries its own bank, otherwise the bank pointer
   assign direct_bank = bus.full ? bus.full_bank : bus.bank_sel;

   // Ports only redirect through their pointers
   assign bus.tgt   = hit0 ? bus.p0 : hit1 ? bus.p1l : hit2 ? bus.p2l : bus.addr;
   assign bus.tbank = hit0 ? 1'b0 :
                      hit1 ? bus.p1h[BANK_BIT] :
                      hit2 ? bus.p2h[BANK_BIT] : direct_bank;

   // A pointer aimed at a port lands on nothing
   assign bus.null_hit = (hit0 | hit1 | hit2) & is_port(bus.tgt);

endmodule

// ===== rtl/bdm_top.sv
// Banked data memory with pointer-based indirect access and accumulator
module bdm_top
   import bdm_pkg::*;
(
   // Clock and reset
   input  wire logic          CLK,
   input  wire logic          RSTN,
   // Data memory access from the core
   input  wire logic          REQ,
   input  wire logic          WR,
   input  wire logic [AW-1:0] ADDR,
   input  wire logic          FULL,
   input  wire logic          FULL_BANK,
   input  wire logic          WSEL_ACC,
   input  wire logic [DW-1:0] WDATA,
   // ALU result load
   input  wire logic          ALU_LOAD,
   input  wire logic [DW-1:0] ALU_RESULT,
   // Read answer and accumulator
   output logic      [DW-1:0] RDATA,
   output logic               RVALID,
   output logic      [DW-1:0] ACC_Q
);

   // ------------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------------
   logic rs1_reg;
   logic rs2_reg;
   logic rst_n;

   // Asynchronous assert, release after two edges to avoid metastability
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rs1_reg <= 1'b0;
         rs2_reg <= 1'b0;
      end else begin
         rs1_reg <= 1'b1;
         rs2_reg <= rs1_reg;
      end
   end
   assign rst_n = rs2_reg;

   // ------------------------------------------------------------------
   // Pointer, bank and accumulator storage
   // ------------------------------------------------------------------
   logic [DW-1:0] p0_reg;
   logic [DW-1:0] p1l_reg;
   logic [DW-1:0] p1h_reg;
   logic [DW-1:0] p2l_reg;
   logic [DW-1:0] p2h_reg;
   logic [DW-1:0] acc_reg;
   logic          bank_reg;
   logic [DW-1:0] acc_next;

   // ------------------------------------------------------------------
   // Address routing
   // ------------------------------------------------------------------
   bdm_acc_if acc_if ();

   assign acc_if.addr      = ADDR;
   assign acc_if.full      = FULL;
   assign acc_if.full_bank = FULL_BANK;
   assign acc_if.bank_sel  = bank_reg;
   assign acc_if.p0        = p0_reg;
   assign acc_if.p1l       = p1l_reg;
   assign acc_if.p1h       = p1h_reg;
   assign acc_if.p2l       = p2l_reg;
   assign acc_if.p2h       = p2h_reg;

   bdm_route u_route (
      .bus (acc_if.route)
   );

   logic [AW-1:0] tgt;
   logic          tbank;
   logic          null_hit;

   assign tgt      = acc_if.tgt;
   assign tbank    = acc_if.tbank;
   assign null_hit = acc_if.null_hit;

   // ------------------------------------------------------------------
   // Location classes
   // ------------------------------------------------------------------
   logic          eec_absent;
   logic          prot_hit;
   logic          flop_hit;
   logic          zero_hit;
   logic          ram_hit;
   logic          wr_ok;
   logic          ram_we;
   logic [DW-1:0] wdata_w;
   logic [DW-1:0] flop_val;
   logic [DW-1:0] ram_q;

   // Addresses count up from the base; eeprom_control only exists in bank 1
   assign eec_absent = (tgt == ADDR_EEC) & ~tbank;
   assign prot_hit   = (tgt == ADDR_PROT);
   assign flop_hit   = (tgt == ADDR_PTR0) | (tgt == ADDR_P1L) | (tgt == ADDR_P1H) |
                       (tgt == ADDR_P2L)  | (tgt == ADDR_P2H) | (tgt == ADDR_ACC) |
                       (tgt == ADDR_BSEL);
   assign zero_hit   = null_hit | eec_absent | prot_hit;
   assign ram_hit    = ~zero_hit & ~flop_hit;

   // No memory-to-memory path: a move reuses the accumulator as source
   assign wdata_w = WSEL_ACC ? acc_reg : WDATA;
   assign wr_ok   = REQ & WR & ~null_hit;
   assign ram_we  = wr_ok & ram_hit;

   // Read value of the flop-backed locations
   assign flop_val = (tgt == ADDR_PTR0) ? p0_reg  :
                     (tgt == ADDR_P1L)  ? p1l_reg :
                     (tgt == ADDR_P1H)  ? p1h_reg :
                     (tgt == ADDR_P2L)  ? p2l_reg :
                     (tgt == ADDR_P2H)  ? p2h_reg :
                     (tgt == ADDR_ACC)  ? acc_reg :
                     {{(DW-1){1'b0}}, bank_reg};

   // ------------------------------------------------------------------
   // Storage array
   // ------------------------------------------------------------------
   bdm_ram u_ram (
      .clk   (CLK),
      .we    (ram_we),
      .idx   (ram_index(tgt, tbank)),
      .wdata (wdata_w),
      .q     (ram_q)
   );

   // ------------------------------------------------------------------
   // Pointer and bank registers
   // ------------------------------------------------------------------
   logic wr_p0;
   logic wr_p1l;
   logic wr_p1h;
   logic wr_p2l;
   logic wr_p2h;
   logic wr_acc;
   logic wr_bsel;

   assign wr_p0   = wr_ok & (tgt == ADDR_PTR0);
   assign wr_p1l  = wr_ok & (tgt == ADDR_P1L);
   assign wr_p1h  = wr_ok & (tgt == ADDR_P1H);
   assign wr_p2l  = wr_ok & (tgt == ADDR_P2L);
   assign wr_p2h  = wr_ok & (tgt == ADDR_P2H);
   assign wr_acc  = wr_ok & (tgt == ADDR_ACC);
   assign wr_bsel = wr_ok & (tgt == ADDR_BSEL);

   // Pointers behave as plain registers, so increments work on them
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         p0_reg  <= PTR_RST;
         p1l_reg <= PTR_RST;
         p1h_reg <= PTR_RST;
         p2l_reg <= PTR_RST;
         p2h_reg <= PTR_RST;
      end else begin
         if (wr_p0)  p0_reg  <= wdata_w;
         if (wr_p1l) p1l_reg <= wdata_w;
         if (wr_p1h) p1h_reg <= wdata_w;
         if (wr_p2l) p2l_reg <= wdata_w;
         if (wr_p2h) p2h_reg <= wdata_w;
      end
   end

   // Software must set the bank before using banked direct addresses
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         bank_reg <= 1'b0;
      end else if (wr_bsel) begin
         bank_reg <= wdata_w[BANK_BIT];
      end
   end

   // ------------------------------------------------------------------
   // Accumulator
   // ------------------------------------------------------------------
   // ALU load wins over a program write in the same cycle
   assign acc_next = ALU_LOAD ? ALU_RESULT : wr_acc ? wdata_w : acc_reg;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         acc_reg <= PTR_RST;
      end else begin
         acc_reg <= acc_next;
      end
   end

   // ------------------------------------------------------------------
   // Read pipeline: array data lands one edge late, then one output stage
   // ------------------------------------------------------------------
   logic          rd1_reg;
   logic          zero1_reg;
   logic          flop1_reg;
   logic [DW-1:0] fval1_reg;
   logic [DW-1:0] rdata_reg;
   logic [DW-1:0] rdata_next;
   logic          rvalid_reg;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         rd1_reg   <= 1'b0;
         zero1_reg <= 1'b0;
         flop1_reg <= 1'b0;
         fval1_reg <= ZERO_DATA;
      end else begin
         rd1_reg   <= REQ & ~WR;
         zero1_reg <= zero_hit;
         flop1_reg <= flop_hit;
         fval1_reg <= flop_val;
      end
   end

   // Ports whose pointer aims at a port, absent and protected locations read as zero
   assign rdata_next = zero1_reg ? ZERO_DATA :
                       flop1_reg ? fval1_reg : ram_q;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg  <= ZERO_DATA;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= rd1_reg;
         if (rd1_reg) rdata_reg <= rdata_next;
      end
   end

   assign RDATA  = rdata_reg;
   assign RVALID = rvalid_reg;
   assign ACC_Q  = acc_reg;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!rst_n);

   sequence read_issue;
      REQ && !WR;
   endsequence

   sequence null_read;
      REQ && !WR && ((ADDR == ADDR_IND0) || (ADDR == ADDR_IND1) ||
                     (ADDR == ADDR_IND2)) && is_port(tgt);
   endsequence

   // Back-to-back reads are legal, so only the answer two edges on is pinned
   sequence answer_two;
      ##2 RVALID;
   endsequence

   // No answer may appear unless a read was taken two edges earlier
   sequence answer_none;
      ##2 !RVALID;
   endsequence

   read_latency_a: assert property (read_issue |-> answer_two)
      else $error("read answer not two cycles after request");

   no_stray_answer_a: assert property (!read_issue |-> answer_none)
      else $error("read answer without a read request");

   null_read_a: assert property (null_read |-> ##2 (RVALID && RDATA == ZERO_DATA))
      else $error("indirect read of a port did not return zero");

   null_write_a: assert property (REQ && WR && null_hit |-> !ram_we ##1 $stable(p0_reg))
      else $error("indirect write of a port changed state");

   ptr_write_a: assert property (REQ && WR && !null_hit && tgt == ADDR_PTR0 && !WSEL_ACC
                                 |=> p0_reg == $past(WDATA))
      else $error("pointer write not stored");

   acc_load_a: assert property (ALU_LOAD |=> ACC_Q == $past(ALU_RESULT))
      else $error("ALU result not held in accumulator");

   port0_bank_a: assert property (REQ && ADDR == ADDR_IND0 |-> !tbank && tgt == p0_reg)
      else $error("port 0 left bank 0");

   port1_route_a: assert property (REQ && ADDR == ADDR_IND1
                                   |-> tgt == p1l_reg && tbank == p1h_reg[BANK_BIT])
      else $error("port 1 routed wrongly");

   direct_bank_a: assert property (REQ && !is_port(ADDR) && !FULL |-> tbank == bank_reg)
      else $error("direct access ignored bank pointer");

   full_bank_a: assert property (REQ && !is_port(ADDR) && FULL |-> tbank == FULL_BANK)
      else $error("full-space access ignored its bank");

   eec_bank0_a: assert property (read_issue ##0 (eec_absent && !null_hit)
                                 |-> ##2 RDATA == ZERO_DATA)
      else $error("eeprom_control visible in bank 0");

   protect_write_a: assert property (REQ && WR && prot_hit |-> !ram_we)
      else $error("protected location written");

   acc_move_a: assert property (REQ && WR && WSEL_ACC && ram_hit
                                |-> ram_we && wdata_w == acc_reg)
      else $error("move did not pass through accumulator");

endmodule

// ===== tb/bdm_core_model.sv
// Core-side model that issues data memory accesses and accumulator loads
module bdm_core_model
   import bdm_pkg::*;
(
   // Clock
   CLK,
   // Requests towards the memory
   REQ, WR, ADDR, FULL, FULL_BANK, WSEL_ACC, WDATA,
   // Accumulator load
   ALU_LOAD, ALU_RESULT,
   // Answers
   RDATA, RVALID
);
   timeunit 1ns;
   timeprecision 1ps;
   input  wire logic          CLK;
   output logic               REQ;
   output logic               WR;
   output logic      [AW-1:0] ADDR;
   output logic               FULL;
   output logic               FULL_BANK;
   output logic               WSEL_ACC;
   output logic      [DW-1:0] WDATA;
   output logic               ALU_LOAD;
   output logic      [DW-1:0] ALU_RESULT;
   input  wire logic [DW-1:0] RDATA;
   input  wire logic          RVALID;

   // Quiet bus at time zero
   initial begin
      REQ = 1'b0;
      WR = 1'b0;
      ADDR = 8'h00;
      FULL = 1'b0;
      FULL_BANK = 1'b0;
      WSEL_ACC = 1'b0;
      WDATA = 8'h00;
      ALU_LOAD = 1'b0;
      ALU_RESULT = 8'h00;
   end

   // Released lines flip so a stale value is never mistaken for a live one
   task automatic release_bus();
      REQ <= 1'b0;
      ALU_LOAD <= 1'b0;
      ADDR <= ~ADDR;
      WDATA <= ~WDATA;
      ALU_RESULT <= ~ALU_RESULT;
   endtask

   // One cycle of request, launched off the falling edge, held over the taking edge
   task automatic drive(input logic rq, wr, input logic [AW-1:0] a, input logic f, fb, ws,
                        input logic [DW-1:0] d, input logic ld, input logic [DW-1:0] av);
      @(negedge CLK);
      REQ <= rq;
      WR <= wr;
      ADDR <= a;
      FULL <= f;
      FULL_BANK <= fb;
      WSEL_ACC <= ws;
      WDATA <= d;
      ALU_LOAD <= ld;
      ALU_RESULT <= av;
      @(posedge CLK);
   endtask

   // Read: request, release, then watch four cycles for the answer
   task automatic rd(input logic [AW-1:0] a, input logic f, fb,
                     output logic [DW-1:0] d, output int lat);
      drive(1'b1, 1'b0, a, f, fb, 1'b0, 8'h00, 1'b0, 8'h00);
      lat = 0;
      d = 8'h00;
      for (int k = 1; k <= 4; k++) begin
         @(negedge CLK);
         if (k == 1) release_bus();
         if (RVALID === 1'b1 && lat == 0) begin
            lat = k;
            d = RDATA;
         end
      end
   endtask
endmodule

// ===== tb/banked_data_memory_indirect_access_tb.sv
// Self-checking bench for the banked data memory with indirect ports
module banked_data_memory_indirect_access_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import bdm_pkg::*;

   // ---------------------------------------------------------------
   // Clock, reset, design and core model
   // ---------------------------------------------------------------
   logic CLK, RSTN, REQ, WR, FULL, FULL_BANK, WSEL_ACC, ALU_LOAD, RVALID;
   logic [7:0] ADDR, WDATA, ALU_RESULT, RDATA, ACC_Q, a;
   logic [7:0] mem_m [0:383];
   logic [31:0] seed;
   int miscompares, total_checks, cycles;

   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end

   bdm_top dut (.CLK(CLK), .RSTN(RSTN), .REQ(REQ), .WR(WR), .ADDR(ADDR), .FULL(FULL),
      .FULL_BANK(FULL_BANK), .WSEL_ACC(WSEL_ACC), .WDATA(WDATA), .ALU_LOAD(ALU_LOAD),
      .ALU_RESULT(ALU_RESULT), .RDATA(RDATA), .RVALID(RVALID), .ACC_Q(ACC_Q));

   bdm_core_model core (.CLK(CLK), .REQ(REQ), .WR(WR), .ADDR(ADDR), .FULL(FULL),
      .FULL_BANK(FULL_BANK), .WSEL_ACC(WSEL_ACC), .WDATA(WDATA), .ALU_LOAD(ALU_LOAD),
      .ALU_RESULT(ALU_RESULT), .RDATA(RDATA), .RVALID(RVALID));

   // ---------------------------------------------------------------
   // Expectation model
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Returns {null access, physical row}; rows: shared, bank 0, bank 1
   function automatic logic [9:0] resolve(input logic [7:0] ad, input logic f, fb);
      logic [7:0] t;
      logic b, ind;
      ind = (ad == ADDR_IND0) || (ad == ADDR_IND1) || (ad == ADDR_IND2);
      t = (ad == ADDR_IND0) ? mem_m[1] : (ad == ADDR_IND1) ? mem_m[3] :
          (ad == ADDR_IND2) ? mem_m[13] : ad;
      b = (ad == ADDR_IND0) ? 1'b0 : (ad == ADDR_IND1) ? mem_m[4][0] :
          (ad == ADDR_IND2) ? mem_m[14][0] : (f ? fb : mem_m[15][0]);
      return {(ind && (t == ADDR_IND0 || t == ADDR_IND1 || t == ADDR_IND2))
              || t == ADDR_PROT || (t == ADDR_EEC && !b),
              t[7] ? 9'h080 + {1'b0, b, t[6:0]} : {2'b00, t[6:0]}};
   endfunction

   // ---------------------------------------------------------------
   // Compare and access tasks
   // ---------------------------------------------------------------
   task automatic chk8(input logic [7:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_lat(input int got, exp);
      total_checks++;
      if (got != exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Write and/or accumulator load, tracked in the expectation model
   task automatic wop(input logic rq, input logic [7:0] ad, input logic f, fb, ws,
                      input logic [7:0] d, input logic ld, input logic [7:0] av);
      logic [9:0] r;
      logic [7:0] wd;
      r = resolve(ad, f, fb);
      wd = ws ? mem_m[5] : d;
      core.drive(rq, 1'b1, ad, f, fb, ws, d, ld, av);
      if (rq && !r[9]) mem_m[r[8:0]] = wd;
      if (ld) mem_m[5] = av;
   endtask

   task automatic wrt(input logic [7:0] ad, d);
      wop(1'b1, ad, 1'b0, 1'b0, 1'b0, d, 1'b0, 8'h00);
   endtask

   // Read with answer latency and accumulator checked alongside
   task automatic rchk(input logic [7:0] ad, input logic f, fb);
      logic [9:0] r;
      logic [7:0] e, d;
      int lat;
      r = resolve(ad, f, fb);
      e = r[9] ? 8'h00 : (r[8:0] == 9'h00F) ? {7'h00, mem_m[15][0]} : mem_m[r[8:0]];
      core.rd(ad, f, fb, d, lat);
      chk8(d, e);
      chk_lat(lat, 2);
      chk8(ACC_Q, mem_m[5]);
   endtask

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Hang guard: the full run needs well under 10000 cycles
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         report_and_stop();
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      RSTN = 1'b0;
      seed = 32'hdcca_8838;
      for (int i = 0; i < 384; i++) mem_m[i] = 8'h00;
      repeat (6) @(negedge CLK);
      RSTN = 1'b1;
      repeat (3) @(posedge CLK);
      // Pointers, bank pointer and accumulator start at zero
      foreach (mem_m[i]) if (i < 16 && i inside {1, 3, 4, 5, 13, 14, 15})
         rchk(8'(i), 1'b0, 1'b0);
      // Fill every location of both banks through the full-space form
      for (int i = 0; i < 512; i++) begin
         seed = lfsr(seed);
         if (i < 256 || i >= 320 || i == 256) wop(1'b1, i[7:0], 1'b1, i >= 256, 1'b0,
            seed[7:0], 1'b0, 8'h00);
      end
      wrt(8'h0F, 8'h01);
      rchk(8'h0F, 1'b0, 1'b0);
      wrt(8'h01, 8'h90);
      wrt(8'h00, 8'h5A);
      rchk(8'h90, 1'b1, 1'b0);
      rchk(8'h90, 1'b0, 1'b0);
      wrt(8'h01, mem_m[1] + 8'h01);
      wrt(8'h00, 8'h33);
      rchk(8'h91, 1'b1, 1'b0);
      wrt(8'h03, 8'hA0);
      wrt(8'h04, 8'h01);
      wrt(8'h02, 8'hC3);
      rchk(8'hA0, 1'b1, 1'b1);
      wrt(8'h0D, 8'h02);
      wrt(8'h0E, 8'h00);
      wrt(8'h0C, 8'h77);
      rchk(8'h0C, 1'b0, 1'b0);
      rchk(8'h02, 1'b0, 1'b0);
      wrt(8'h0F, 8'h00);
      wrt(8'h40, 8'h11);
      rchk(8'h40, 1'b0, 1'b0);
      rchk(8'h40, 1'b1, 1'b1);
      wrt(8'h20, 8'h4E);
      rchk(8'h20, 1'b1, 1'b1);
      wrt(8'h08, 8'hFF);
      rchk(8'h08, 1'b0, 1'b0);
      rchk(8'h00, 1'b0, 1'b0);
      wop(1'b0, 8'h05, 1'b0, 1'b0, 1'b0, 8'h00, 1'b1, 8'h3C);
      rchk(8'h05, 1'b0, 1'b0);
      wop(1'b1, 8'h05, 1'b0, 1'b0, 1'b0, 8'hAA, 1'b1, 8'hC5);
      rchk(8'h05, 1'b0, 1'b0);
      wop(1'b1, 8'h85, 1'b0, 1'b0, 1'b1, 8'h00, 1'b0, 8'h00);
      rchk(8'h85, 1'b0, 1'b0);
      // Random mix, biased towards the special low addresses
      for (int i = 0; i < 800; i++) begin
         seed = lfsr(seed);
         a = seed[8] ? seed[7:0] : {4'h0, seed[3:0]};
         if (seed[11:9] inside {3'd3, 3'd4}) rchk(a, seed[12], seed[13]);
         else wop(seed[11:9] != 3'd5, a, seed[12], seed[13], seed[11:9] == 3'd6,
            seed[23:16], seed[11:9] >= 3'd5, seed[31:24]);
      end
      rchk(8'h05, 1'b0, 1'b0);
      report_and_stop();
   end
endmodule
